// [core/tsogc_ctrl.sv]
/*
  Group-select, pin master enable and PWM output control for a timer.
  Assumes timer requests and waveforms come from logic on aclk.
*/
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module tsogc_ctrl
  import tsogc_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
)(
  // Clock and reset
  input  wire  logic              aclk,
  input  wire  logic              aresetn,
  // AXI4-Lite write
  input  wire  logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire  logic              s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire  logic [31:0]       s_axi_wdata,
  input  wire  logic [3:0]        s_axi_wstrb,
  input  wire  logic              s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire  logic              s_axi_bready,
  // AXI4-Lite read
  input  wire  logic [ADDR_W-1:0] s_axi_araddr,
  input  wire  logic              s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire  logic              s_axi_rready,
  // Counter side
  input  wire  logic [NCH-1:0]    preset_req,
  input  wire  logic [NCH-1:0]    clear_req,
  input  wire  logic [NCH-1:0]    clear_source_sel,
  output logic [NCH-1:0]          ch_preset,
  output logic [NCH-1:0]          ch_clear,
  // Mode and waveform side
  input  wire  logic              pwm_mode,
  input  wire  logic              comp_mode,
  input  wire  logic              dead_time_done,
  input  wire  logic              period_tick,
  input  wire  logic [NPIN-1:0]   wave_act,
  input  wire  logic [NPIN-1:0]   wave_raw,
  // Pins
  output logic [NPIN-1:0]         wave_pin_o,
  output logic [NPIN-1:0]         wave_pin_oe_n,
  output logic                    period_toggle
);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] reg_sel(input logic [7:0] a,
                                         input logic [7:0] g,
                                         input logic [7:0] o,
                                         input logic [7:0] c);
    reg_sel = (a == GRP_OFF) ? g : (a == OE_OFF) ? o : (a == OCR_OFF) ? c : 8'h00;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == GRP_OFF) || (a == OE_OFF) || (a == OCR_OFF);
  endfunction

  // Another grouped channel raised the event
  function automatic logic from_group(input logic [NCH-1:0] ev,
                                      input logic [NCH-1:0] grp,
                                      input int unsigned    i);
    logic [NCH-1:0] others;
    others    = ev & grp;
    others[i] = 1'b0;
    from_group = grp[i] & (|others);
  endfunction

  // ==========================================================
  // Registers and bus state
  logic [7:0]        grp_q;
  logic [7:0]        oe_q;
  logic [7:0]        ocr_q;
  logic              aw_got_q;
  logic              w_got_q;
  logic [7:0]        waddr_q;
  logic [7:0]        wdata_q;
  logic              wstrb_q;
  logic [NCH-1:0]    grp_vec;
  logic              do_write;

  assign grp_vec  = {grp_q[GRP_CH_E_BIT], grp_q[GRP_CH_D_BIT], grp_q[2:0]};
  assign do_write = aw_got_q && w_got_q && !s_axi_bvalid;

  // ==========================================================
  // Write channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      waddr_q       <= 8'h00;
      wdata_q       <= 8'h00;
      wstrb_q       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q      <= 1'b1;
        waddr_q       <= 8'(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q      <= 1'b1;
        wdata_q      <= s_axi_wdata[7:0];
        wstrb_q      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Register file; fixed bits never take write data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      grp_q <= GRP_RST;
      oe_q  <= OE_RST;
      ocr_q <= OCR_RST;
    end
    else if (do_write && wstrb_q)
    begin
      if (waddr_q == GRP_OFF)
        grp_q <= (wdata_q & GRP_WMASK) | GRP_FIXED;
      if (waddr_q == OE_OFF)
        oe_q <= (wdata_q & OE_WMASK) | OE_FIXED;
      if (waddr_q == OCR_OFF)
        ocr_q <= (wdata_q & OCR_WMASK) | OCR_FIXED;
    end
  end

  // ==========================================================
  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, reg_sel(8'(s_axi_araddr), grp_q, oe_q, ocr_q)};
      s_axi_rresp   <= mapped(8'(s_axi_araddr)) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Synchronous preset and clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ch_preset <= '0;
      ch_clear  <= '0;
    end
    else
    begin
      for (int unsigned i = 0; i < NCH; i++)
      begin
        ch_preset[i] <= preset_req[i] | from_group(preset_req, grp_vec, i);
        ch_clear[i]  <= clear_req[i]
                      | (clear_source_sel[i] & from_group(clear_req, grp_vec, i));
      end
    end
  end

  // ==========================================================
  // Pin gating and output levels
  logic [NPIN-1:0] act_eff;
  logic [NPIN-1:0] lvl_sel;
  logic [NPIN-1:0] pin_d;

  // Pins 2..0 positive phase, pins 5..3 reverse phase
  assign lvl_sel = {{3{ocr_q[OCR_N_BIT]}}, {3{ocr_q[OCR_P_BIT]}}};
  assign act_eff = {wave_act[5:3] & {3{!comp_mode || dead_time_done}}, wave_act[2:0]};
  assign pin_d   = pwm_mode ? ((act_eff & lvl_sel) | (~act_eff & ~lvl_sel)) : wave_raw;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wave_pin_o    <= '0;
      wave_pin_oe_n <= '1;
    end
    else
    begin
      wave_pin_o    <= pin_d & oe_q[NPIN-1:0];
      wave_pin_oe_n <= ~oe_q[NPIN-1:0];
    end
  end

  // ==========================================================
  // Period toggle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      period_toggle <= 1'b0;
    else if (!pwm_mode || !ocr_q[OCR_TOG_BIT])
      period_toggle <= 1'b0;
    else if (period_tick)
      period_toggle <= !period_toggle;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_GRP_RESERVED: assert property (grp_q[5:3] == 3'h0)
    else $error("group reserved bits not zero");
  AST_OE_FIXED: assert property (oe_q[7:6] == 2'h3)
    else $error("enable reserved bits not one");
  AST_OCR_RESERVED: assert property ((ocr_q & ~OCR_WMASK) == 8'h00)
    else $error("output control reserved bits not zero");
  AST_PIN_DISABLED: assert property (!oe_q[0] |=> wave_pin_oe_n[0] && !wave_pin_o[0])
    else $error("disabled pin driven");
  AST_INDEP: assert property (!grp_vec[0] && !preset_req[0] |=> !ch_preset[0])
    else $error("independent channel preset by another");
  AST_GRP_PRESET: assert property (grp_vec[4] && grp_vec[0] && preset_req[0] |=> ch_preset[4])
    else $error("grouped channel missed preset");
  AST_GRP_CLEAR: assert property (grp_vec[1] && !clear_source_sel[1] && !clear_req[1]
                                  |=> !ch_clear[1])
    else $error("clear without clear source");
  AST_TOG_OFF: assert property (!pwm_mode |=> !period_toggle)
    else $error("toggle outside pwm mode");
  AST_TOG_FLIP: assert property (pwm_mode && ocr_q[OCR_TOG_BIT] && period_tick
                                 && $past(pwm_mode) && $past(ocr_q[OCR_TOG_BIT])
                                 |=> period_toggle != $past(period_toggle))
    else $error("toggle missed period");
  AST_DEAD: assert property (pwm_mode && comp_mode && !dead_time_done && oe_q[3]
                             |=> wave_pin_o[3] == !$past(ocr_q[OCR_N_BIT]))
    else $error("reverse phase left initial level early");
  AST_LEVEL: assert property (pwm_mode && oe_q[0] && wave_act[0]
                              |=> wave_pin_o[0] == $past(ocr_q[OCR_P_BIT]))
    else $error("positive active level wrong");
  AST_RESP: assert property (do_write |=> s_axi_bvalid)
    else $error("write not answered");
  AST_GRP_CLEAR_ON: assert property (grp_vec[4] && grp_vec[0] && clear_source_sel[4]
                                     && clear_req[0] |=> ch_clear[4])
    else $error("grouped channel missed clear");
  AST_GRP_PAIR: assert property (grp_vec[1] && grp_vec[0] && preset_req[0]
                                 |=> ch_preset[1])
    else $error("low channel missed group preset");
  AST_PIN_ENABLED: assert property (oe_q[5]
                                    |=> !wave_pin_oe_n[5])
    else $error("enabled pin not driven");
  AST_RAW: assert property (!pwm_mode && oe_q[1]
                            |=> wave_pin_o[1] == $past(wave_raw[1]))
    else $error("ordinary waveform not passed");
  AST_REV_LEVEL: assert property (pwm_mode && oe_q[4] && wave_act[4] && (!comp_mode || dead_time_done)
                                  |=> wave_pin_o[4] == $past(ocr_q[OCR_N_BIT]))
    else $error("reverse active level wrong");
  AST_TOG_HOLD: assert property (pwm_mode && ocr_q[OCR_TOG_BIT] && !period_tick
                                 |=> period_toggle == $past(period_toggle))
    else $error("toggle moved without period");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready
                                  |=> s_axi_rvalid)
    else $error("read not answered");
  AST_RD_UPPER: assert property (s_axi_rvalid
                                 |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read upper bits not zero");

endmodule
`default_nettype wire

// [core/tsogc_pkg.sv]
/*
  Constants for the timer group-select and output gate control block.
  Assumes a 32-bit AXI4-Lite register bus with one word per register.
*/
// Function
// - Group bits for channels 4 and 3 make them join synchronous preset/clear.
// - Group bits 2..0 join channels 2..0 to the group; reset 0.
// - A channel with group bit 0 ignores other channels' presets and clears.
// - Group clear needs group bit and the channel's clear source selected.
// - Group register bits 5..3 read 0; software writes 0.
// - Six enable bits gate channel 3/4 waveforms onto pins; reset 0.
// - Enable register bits 7 and 6 read 1; software writes 1.
// - Output control bit 6 enables the period toggle output; reset 0.
// - Toggle and level settings act only in the two PWM modes.
// - Output control bit 1 selects reverse-phase level; reset 0.
// - Output control bit 0 selects positive-phase level; reset 0.
// - Output control bits 7 and 5..2 read 0; software writes 0.
// - Complementary mode: reverse phase holds initial level until dead time ends.
package tsogc_pkg;
  localparam int unsigned NCH  = 5;
  localparam int unsigned NPIN = 6;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] GRP_OFF = 8'h00;
  localparam logic [7:0] OE_OFF  = 8'h04;
  localparam logic [7:0] OCR_OFF = 8'h08;
  // ==========================================================
  // Field positions and masks
  localparam int unsigned GRP_CH_E_BIT = 7;
  localparam int unsigned GRP_CH_D_BIT = 6;
  localparam int unsigned OCR_TOG_BIT  = 6;
  localparam int unsigned OCR_N_BIT    = 1;
  localparam int unsigned OCR_P_BIT    = 0;
  localparam logic [7:0]  GRP_WMASK    = 8'hC7;
  localparam logic [7:0]  OE_WMASK     = 8'h3F;
  localparam logic [7:0]  OCR_WMASK    = 8'h43;
  // ==========================================================
  // Reset and fixed values
  localparam logic [7:0] GRP_FIXED = 8'h00;
  localparam logic [7:0] OE_FIXED  = 8'hC0;
  localparam logic [7:0] OCR_FIXED = 8'h00;
  localparam logic [7:0] GRP_RST   = 8'h00;
  localparam logic [7:0] OE_RST    = 8'hC0;
  localparam logic [7:0] OCR_RST   = 8'h00;
  // ==========================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [verif/tsogc_stage.sv]
/*
  Power stage model seen by the six gated waveform pins.
  Assumes pins have no pull: a released pin shows the inverse of its last level.
*/
`timescale 1ns/1ps
`default_nettype none
module tsogc_stage
(
  // Clock
  input  wire logic       aclk,
  // Pin drive
  input  wire logic [5:0] drv,
  input  wire logic [5:0] oe_n,
  // Resolved level
  output logic      [5:0] pin
);
  logic [5:0] last_q = 6'h00;
  // ==========================================================
  // Remember the last driven level of each pin
  always_ff @(posedge aclk)
  begin
    last_q <= (oe_n & last_q) | (~oe_n & drv);
  end
  assign pin = (oe_n & ~last_q) | (~oe_n & drv);
endmodule
`default_nettype wire

// [verif/timer_sync_output_gate_ctrl_tb.sv]
/*
  Self-checking bench of the group-select and pin gate block.
  Assumes the block answers on AXI4-Lite and samples inputs on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module timer_sync_output_gate_ctrl_tb;
  import tsogc_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, ptog;
  logic [1:0] bresp, rresp;
  logic [4:0] preq = 0, creq = 0, csel = 0, chp, chc;
  logic pwm = 0, comp = 0, dtd = 0, tick = 0;
  logic [5:0] act = 0, raw = 0, pin_o, oe_n, pin;
  int err_count = 0, checked = 0;
  always #20 aclk = ~aclk;
  tsogc_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .preset_req(preq), .clear_req(creq),
    .clear_source_sel(csel), .ch_preset(chp), .ch_clear(chc), .pwm_mode(pwm),
    .comp_mode(comp), .dead_time_done(dtd), .period_tick(tick), .wave_act(act),
    .wave_raw(raw), .wave_pin_o(pin_o), .wave_pin_oe_n(oe_n), .period_toggle(ptog));
  tsogc_stage stage (.aclk(aclk), .drv(pin_o), .oe_n(oe_n), .pin(pin));
  // ==========================================================
  // Bus cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    bit aw, w;
    aw = 1;
    w = 1;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    while (aw || w)
    begin
      @(posedge aclk);
      if (aw && awready)
      begin
        aw = 0;
        awvalid <= 0;
      end
      if (w && wready)
      begin
        w = 0;
        wvalid <= 0;
      end
    end
    bready <= 1;
    do @(posedge aclk); while (!bvalid);
    bready <= 0;
    `CHK(bresp, er)
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    rready <= 1;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
    `CHK(rdata, {24'h0, e})
    `CHK(rresp, er)
  endtask
  task automatic settle();
    repeat (2) @(posedge aclk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd(GRP_OFF, 8'h00, RESP_OKAY);
    rd(OE_OFF, 8'hC0, RESP_OKAY);
    rd(OCR_OFF, 8'h00, RESP_OKAY);
    rd(8'h0C, 8'h00, RESP_SLVERR);
    wr(8'h0C, 8'hFF, RESP_SLVERR);
    wr(GRP_OFF, 8'hFF, RESP_OKAY);
    rd(GRP_OFF, 8'hC7, RESP_OKAY);
    wr(OE_OFF, 8'h00, RESP_OKAY);
    rd(OE_OFF, 8'hC0, RESP_OKAY);
    wr(OCR_OFF, 8'hFF, RESP_OKAY);
    rd(OCR_OFF, 8'h43, RESP_OKAY);
    wstrb <= 4'h0;
    wr(OCR_OFF, 8'h00, RESP_OKAY);
    wstrb <= 4'hF;
    rd(OCR_OFF, 8'h43, RESP_OKAY);
    $display("TEST regs done");
  endtask
  task automatic t_sync();
    wr(GRP_OFF, 8'hC3, RESP_OKAY);
    preq <= 5'h01;
    csel <= 5'h12;
    creq <= 5'h01;
    settle();
    `CHK(chp, 5'h1B)
    `CHK(chc, 5'h13)
    preq <= 5'h04;
    creq <= 5'h00;
    settle();
    `CHK(chp, 5'h04)
    preq <= 5'h00;
    $display("TEST sync done");
  endtask
  task automatic t_pins();
    wr(OE_OFF, 8'hFF, RESP_OKAY);
    wr(OCR_OFF, 8'h01, RESP_OKAY);
    pwm <= 1;
    act <= 6'h3F;
    settle();
    `CHK(pin, 6'h07)
    act <= 6'h00;
    settle();
    `CHK(pin, 6'h38)
    act <= 6'h3F;
    comp <= 1;
    settle();
    `CHK(pin, 6'h3F)
    dtd <= 1;
    settle();
    `CHK(pin, 6'h07)
    wr(OCR_OFF, 8'h02, RESP_OKAY);
    settle();
    `CHK(pin, 6'h38)
    pwm <= 0;
    raw <= 6'h0F;
    settle();
    `CHK(pin_o, 6'h0F)
    wr(OE_OFF, 8'h05, RESP_OKAY);
    settle();
    `CHK(oe_n, 6'h3A)
    `CHK(pin_o, 6'h05)
    $display("TEST pins done");
  endtask
  task automatic t_toggle(input logic [7:0] ocr, input logic m, input logic e);
    wr(OCR_OFF, ocr, RESP_OKAY);
    pwm <= m;
    settle();
    tick <= 1;
    @(posedge aclk);
    tick <= 0;
    settle();
    `CHK(ptog, e)
    $display("TEST toggle done");
  endtask
  task automatic t_reset();
    aresetn <= 0;
    settle();
    `CHK(oe_n, 6'h3F)
    `CHK(pin_o, 6'h00)
    `CHK(ptog, 1'b0)
    aresetn <= 1;
    rd(GRP_OFF, 8'h00, RESP_OKAY);
    rd(OE_OFF, 8'hC0, RESP_OKAY);
    rd(OCR_OFF, 8'h00, RESP_OKAY);
    $display("TEST reset done");
  endtask
  task automatic end_of_test();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #200us;
    err_count++;
    end_of_test();
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    t_regs();
    t_sync();
    t_pins();
    t_toggle(8'h00, 1'b1, 1'b0);
    t_toggle(8'h40, 1'b0, 1'b0);
    t_toggle(8'h40, 1'b1, 1'b1);
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
